/* File: rtl/gcpd_pkg.sv */
package gcpd_pkg;
    // Destination port and command code of the general packet
    localparam logic [15:0] CFG_PORT = 16'h0400;
    localparam logic [7:0] CMD_GENERAL = 8'h00;
    // Payload positions
    localparam logic [5:0] B_CMD = 6'h04;
    localparam logic [5:0] B_PAIR_FIRST = 6'h05;
    localparam logic [5:0] B_PAIR_LAST = 6'h16;
    localparam logic [5:0] B_WB_EN = 6'h17;
    localparam logic [5:0] B_SAMP_HI = 6'h18;
    localparam logic [5:0] B_SAMP_LO = 6'h19;
    localparam logic [5:0] B_SAMP_BITS = 6'h1a;
    localparam logic [5:0] B_RATE = 6'h1b;
    localparam logic [5:0] B_PKTS = 6'h1c;
    localparam logic [5:0] B_FEAT = 6'h25;
    localparam logic [5:0] B_TIMER = 6'h26;
    localparam logic [5:0] B_FMT = 6'h27;
    localparam logic [5:0] B_BACKPL = 6'h38;
    localparam logic [5:0] B_REF = 6'h39;
    localparam logic [5:0] B_AMP = 6'h3a;
    localparam logic [5:0] B_FILT = 6'h3b;
    localparam logic [5:0] B_LAST = 6'h3b;
    localparam logic [5:0] IDX_MAX = 6'h3f;
    // Port fields in payload order: ddc cmd, duc cmd, hp in, hp out,
    // audio, duc iq, ddc base, mic, wideband base
    localparam int NUM_PORTS = 9;
    localparam logic [8:0][15:0] PORT_DEFAULTS = {
        16'h0403, 16'h0402, 16'h040b, 16'h0405, 16'h0404,
        16'h0401, 16'h0403, 16'h0402, 16'h0401};
    // Wideband defaults
    localparam logic [15:0] WB_SAMPLES_DEF = 16'h0200;
    localparam logic [7:0] WB_BITS_DEF = 8'h10;
    localparam logic [7:0] WB_RATE_DEF_MS = 8'h14;
    localparam logic [7:0] WB_PKTS_DEF = 8'h20;
    // Field positions
    localparam int FEAT_TSTAMP = 0;
    localparam int FEAT_VITA = 1;
    localparam int FEAT_VNA = 2;
    localparam int FEAT_PHASE = 3;
    localparam int TIMER_BIT = 0;
    localparam int FMT_BIG = 0;
    localparam int FMT_LITTLE = 1;
    localparam int AMP_PA = 0;
    localparam int AMP_TUNER = 1;
    localparam int AMP_COMMON = 2;
    localparam int AMP_CLKSRC = 3;
    localparam int BACKPL_W = 3;
    localparam int REF_W = 2;
    // Receive state; IDLE, RECV and DROP coded 0, 1 and 3
    typedef enum logic [1:0] {
        GCPD_IDLE = 2'h0,
        GCPD_RECV = 2'h1,
        GCPD_DROP = 2'h3
    } gcpd_state_t;
endpackage : gcpd_pkg

/* File: rtl/gcpd_port_sel.sv */
`timescale 1ns/1ps
module gcpd_port_sel #(
    parameter logic [15:0] DEFAULT_PORT = 16'h0000
) (
    input wire logic [15:0] raw,
    output logic [15:0] port
);
    // A zero field falls back to the default port
    assign port = (raw == 16'h0000) ? DEFAULT_PORT : raw;
endmodule : gcpd_port_sel

/* File: rtl/gcpd_decoder.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Only payloads addressed to port 1024 are accepted.
// - Byte 4 must hold command 0x00 to be taken as general packet.
// - Bytes 5,6 give DDC command port; zero means 1025.
// - Bytes 7,8 give DUC command port; zero means 1026.
// - Bytes 9,10 give high-priority inbound port; zero means 1027.
// - Bytes 11,12 give high-priority status source port; zero means 1025.
// - Bytes 13,14 give DDC audio port; zero means 1028.
// - Port fields assemble to 16 bits, first byte high in big-endian order, first byte low in little-endian.
// - Bytes 17,18 give DDC base port, default 1035; stream n adds n.
// - Bytes 21,22 give wideband base, default 1027; stream n adds n.
// - Bytes 15,16 give DUC I/Q base port, default 1029.
// - Bytes 19,20 give microphone port, default 1026.
// - Byte 23 bit k enables wideband stream k.
// - Samples per packet 512, sample bits 16, packets per frame 32 defaults.
// - Byte 27 sets wideband frame interval in ms, default 20.
// - Byte 37 gives time stamp, VITA-49, analyser and phase-word flags.
// - Byte 38 bit 0 enables the hardware timer.
// - Byte 39 selects byte order and sample format; bytes 40,41 ignored.
// - Byte 56 bits 2:0 backplane config; byte 57 bits 1:0 reference.
// - Byte 58 amplifier, tuner, common freq, clock; byte 59 filter boards.
// - First packet after discovery is big-endian unless a packet commits in the discovery cycle; its order applies later.
module gcpd_decoder (
    input wire logic clk,
    input wire logic resetn,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_last,
    input wire logic [15:0] rx_dst_port,
    input wire logic discovery_done,
    input wire logic [6:0] ddc_sel,
    input wire logic [2:0] wb_sel,
    output logic [15:0] ddc_cmd_port,
    output logic [15:0] duc_cmd_port,
    output logic [15:0] hp_rx_port,
    output logic [15:0] hp_tx_port,
    output logic [15:0] ddc_audio_port,
    output logic [15:0] duc_iq_port,
    output logic [15:0] ddc_base_port,
    output logic [15:0] mic_port,
    output logic [15:0] wb_base_port,
    output logic [15:0] ddc_sel_port,
    output logic [15:0] wb_sel_port,
    output logic [7:0] wb_stream_enable,
    output logic [15:0] wb_samples,
    output logic [7:0] wb_sample_bits,
    output logic [7:0] wb_rate_ms,
    output logic [7:0] wb_packets,
    output logic time_stamp_enable,
    output logic vita49_enable,
    output logic vna_mode,
    output logic phase_word_mode,
    output logic hw_timer_enable,
    output logic [7:0] data_format,
    output logic little_endian,
    output logic [2:0] backplane_cfg,
    output logic [1:0] ref_source,
    output logic pa_enable,
    output logic tuner_enable,
    output logic common_freq_enable,
    output logic clock_source,
    output logic [7:0] filter_enable,
    output logic cfg_update,
    output logic cfg_reject
);
    gcpd_pkg::gcpd_state_t state, next_state;
    logic [5:0] idx, next_idx;
    logic [5:0] cur_idx;
    logic beat_bad;
    logic commit;
    logic reject;
    logic [15:0] sh_port [gcpd_pkg::NUM_PORTS];
    logic [15:0] next_sh_port [gcpd_pkg::NUM_PORTS];
    logic [15:0] eff_port [gcpd_pkg::NUM_PORTS];
    logic [15:0] port_q [gcpd_pkg::NUM_PORTS];
    logic [15:0] next_port_q [gcpd_pkg::NUM_PORTS];
    logic [15:0] sh_samples, next_sh_samples;
    logic [7:0] sh_wb_en, sh_bits, sh_rate, sh_pkts, sh_feat, sh_timer;
    logic [7:0] sh_fmt, sh_backpl, sh_ref, sh_amp, sh_filt;
    logic [7:0] next_sh_wb_en, next_sh_bits, next_sh_rate, next_sh_pkts;
    logic [7:0] next_sh_feat, next_sh_timer, next_sh_fmt, next_sh_backpl;
    logic [7:0] next_sh_ref, next_sh_amp, next_sh_filt;
    logic [5:0] pair_off;
    logic pair_hi;
    logic samp_hi;
    logic [7:0] wb_sample_bits_eff;

    // Beat position and validity; the index saturates so long payloads stay dropped-safe
    assign cur_idx = (state == gcpd_pkg::GCPD_IDLE) ? 6'h00 : idx;
    assign beat_bad = (rx_dst_port != gcpd_pkg::CFG_PORT) ||
        (cur_idx == gcpd_pkg::B_CMD && rx_byte != gcpd_pkg::CMD_GENERAL);
    assign commit = rx_valid && rx_last && state != gcpd_pkg::GCPD_DROP && !beat_bad &&
        cur_idx >= gcpd_pkg::B_LAST;
    assign reject = rx_valid && rx_last && !commit;

    // Receive state machine
    always_comb
    begin
        next_state = state;
        next_idx = idx;
        if (rx_valid)
        begin
            if (rx_last)
            begin
                next_state = gcpd_pkg::GCPD_IDLE;
                next_idx = 6'h00;
            end
            else
            begin
                next_state = (beat_bad || state == gcpd_pkg::GCPD_DROP) ?
                    gcpd_pkg::GCPD_DROP : gcpd_pkg::GCPD_RECV;
                next_idx = (cur_idx == gcpd_pkg::IDX_MAX) ? cur_idx : cur_idx + 6'h01;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            state <= gcpd_pkg::GCPD_IDLE;
            idx <= 6'h00;
        end
        else
        begin
            state <= next_state;
            idx <= next_idx;
        end
    end

    // Byte placement in pairs follows little_endian, set by the last committed packet and cleared by discovery
    assign pair_off = cur_idx - gcpd_pkg::B_PAIR_FIRST;
    assign pair_hi = !pair_off[0] ^ little_endian;
    assign samp_hi = (cur_idx == gcpd_pkg::B_SAMP_HI) ^ little_endian;

    // Shadow capture; committed settings are untouched until the packet ends
    always_comb
    begin
        next_sh_port = sh_port;
        next_sh_samples = sh_samples;
        next_sh_wb_en = sh_wb_en;
        next_sh_bits = sh_bits;
        next_sh_rate = sh_rate;
        next_sh_pkts = sh_pkts;
        next_sh_feat = sh_feat;
        next_sh_timer = sh_timer;
        next_sh_fmt = sh_fmt;
        next_sh_backpl = sh_backpl;
        next_sh_ref = sh_ref;
        next_sh_amp = sh_amp;
        next_sh_filt = sh_filt;
        if (rx_valid && state != gcpd_pkg::GCPD_DROP)
        begin
            if (cur_idx >= gcpd_pkg::B_PAIR_FIRST && cur_idx <= gcpd_pkg::B_PAIR_LAST)
            begin
                if (pair_hi)
                    next_sh_port[pair_off[4:1]][15:8] = rx_byte;
                else
                    next_sh_port[pair_off[4:1]][7:0] = rx_byte;
            end
            // Bytes 40, 41 and the unused ranges fall to default
            case (cur_idx)
                gcpd_pkg::B_WB_EN: next_sh_wb_en = rx_byte;
                gcpd_pkg::B_SAMP_HI, gcpd_pkg::B_SAMP_LO:
                begin
                    if (samp_hi)
                        next_sh_samples[15:8] = rx_byte;
                    else
                        next_sh_samples[7:0] = rx_byte;
                end
                gcpd_pkg::B_SAMP_BITS: next_sh_bits = rx_byte;
                gcpd_pkg::B_RATE: next_sh_rate = rx_byte;
                gcpd_pkg::B_PKTS: next_sh_pkts = rx_byte;
                gcpd_pkg::B_FEAT: next_sh_feat = rx_byte;
                gcpd_pkg::B_TIMER: next_sh_timer = rx_byte;
                gcpd_pkg::B_FMT: next_sh_fmt = rx_byte;
                gcpd_pkg::B_BACKPL: next_sh_backpl = rx_byte;
                gcpd_pkg::B_REF: next_sh_ref = rx_byte;
                gcpd_pkg::B_AMP: next_sh_amp = rx_byte;
                gcpd_pkg::B_FILT: next_sh_filt = rx_byte;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < gcpd_pkg::NUM_PORTS; i++)
                sh_port[i] <= 16'h0000;
            sh_samples <= 16'h0000;
            sh_wb_en <= 8'h00;
            sh_bits <= 8'h00;
            sh_rate <= 8'h00;
            sh_pkts <= 8'h00;
            sh_feat <= 8'h00;
            sh_timer <= 8'h00;
            sh_fmt <= 8'h00;
            sh_backpl <= 8'h00;
            sh_ref <= 8'h00;
            sh_amp <= 8'h00;
            sh_filt <= 8'h00;
        end
        else
        begin
            sh_port <= next_sh_port;
            sh_samples <= next_sh_samples;
            sh_wb_en <= next_sh_wb_en;
            sh_bits <= next_sh_bits;
            sh_rate <= next_sh_rate;
            sh_pkts <= next_sh_pkts;
            sh_feat <= next_sh_feat;
            sh_timer <= next_sh_timer;
            sh_fmt <= next_sh_fmt;
            sh_backpl <= next_sh_backpl;
            sh_ref <= next_sh_ref;
            sh_amp <= next_sh_amp;
            sh_filt <= next_sh_filt;
        end
    end

    // Zero-to-default substitution for every port field
    for (genvar g = 0; g < gcpd_pkg::NUM_PORTS; g++)
    begin : g_port
        gcpd_port_sel #(
            .DEFAULT_PORT(gcpd_pkg::PORT_DEFAULTS[g])
        ) u_sel (
            .raw(sh_port[g]),
            .port(eff_port[g])
        );
    end

    assign wb_sample_bits_eff = (sh_bits == 8'h00) ? gcpd_pkg::WB_BITS_DEF : sh_bits;

    // Committed port table
    always_comb
    begin
        next_port_q = port_q;
        if (commit)
            next_port_q = eff_port;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < gcpd_pkg::NUM_PORTS; i++)
                port_q[i] <= gcpd_pkg::PORT_DEFAULTS[i];
        end
        else
            port_q <= next_port_q;
    end

    assign ddc_cmd_port = port_q[0];
    assign duc_cmd_port = port_q[1];
    assign hp_rx_port = port_q[2];
    assign hp_tx_port = port_q[3];
    assign ddc_audio_port = port_q[4];
    assign duc_iq_port = port_q[5];
    assign ddc_base_port = port_q[6];
    assign mic_port = port_q[7];
    assign wb_base_port = port_q[8];

    // Committed settings, loaded in one cycle so they change together
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            wb_stream_enable <= 8'h00;
            wb_samples <= gcpd_pkg::WB_SAMPLES_DEF;
            wb_sample_bits <= gcpd_pkg::WB_BITS_DEF;
            wb_rate_ms <= gcpd_pkg::WB_RATE_DEF_MS;
            wb_packets <= gcpd_pkg::WB_PKTS_DEF;
            time_stamp_enable <= 1'b0;
            vita49_enable <= 1'b0;
            vna_mode <= 1'b0;
            phase_word_mode <= 1'b0;
            hw_timer_enable <= 1'b0;
            data_format <= 8'h00;
            backplane_cfg <= 3'h0;
            ref_source <= 2'h0;
            pa_enable <= 1'b0;
            tuner_enable <= 1'b0;
            common_freq_enable <= 1'b0;
            clock_source <= 1'b0;
            filter_enable <= 8'h00;
        end
        else if (commit)
        begin
            wb_stream_enable <= sh_wb_en;
            wb_samples <= sh_samples;
            wb_sample_bits <= wb_sample_bits_eff;
            wb_rate_ms <= sh_rate;
            wb_packets <= sh_pkts;
            time_stamp_enable <= sh_feat[gcpd_pkg::FEAT_TSTAMP];
            vita49_enable <= sh_feat[gcpd_pkg::FEAT_VITA];
            vna_mode <= sh_feat[gcpd_pkg::FEAT_VNA];
            phase_word_mode <= sh_feat[gcpd_pkg::FEAT_PHASE];
            hw_timer_enable <= sh_timer[gcpd_pkg::TIMER_BIT];
            data_format <= sh_fmt;
            backplane_cfg <= sh_backpl[gcpd_pkg::BACKPL_W-1:0];
            ref_source <= sh_ref[gcpd_pkg::REF_W-1:0];
            pa_enable <= sh_amp[gcpd_pkg::AMP_PA];
            tuner_enable <= sh_amp[gcpd_pkg::AMP_TUNER];
            common_freq_enable <= sh_amp[gcpd_pkg::AMP_COMMON];
            clock_source <= sh_amp[gcpd_pkg::AMP_CLKSRC];
            filter_enable <= next_sh_filt; // Byte 59 can arrive on the commit beat
        end
    end

    // Byte order: discovery forces big-endian, a packet committing alongside wins
    always_ff @(posedge clk)
    begin
        if (!resetn)
            little_endian <= 1'b0;
        else if (commit)
            little_endian <= sh_fmt[gcpd_pkg::FMT_LITTLE] && !sh_fmt[gcpd_pkg::FMT_BIG];
        else if (discovery_done)
            little_endian <= 1'b0;
    end

    // Per-stream port lookup, one cycle of latency
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            ddc_sel_port <= gcpd_pkg::PORT_DEFAULTS[6];
            wb_sel_port <= gcpd_pkg::PORT_DEFAULTS[8];
            cfg_update <= 1'b0;
            cfg_reject <= 1'b0;
        end
        else
        begin
            ddc_sel_port <= ddc_base_port + {9'h000, ddc_sel};
            wb_sel_port <= wb_base_port + {13'h0000, wb_sel};
            cfg_update <= commit;
            cfg_reject <= reject;
        end
    end

    // Checks
    logic chk_cmd_bad;
    always_ff @(posedge clk)
    begin
        if (!resetn || (rx_valid && rx_last))
            chk_cmd_bad <= 1'b0;
        else if (rx_valid && cur_idx == gcpd_pkg::B_CMD && rx_byte != gcpd_pkg::CMD_GENERAL)
            chk_cmd_bad <= 1'b1;
    end

    sequence seq_end_beat;
        rx_valid && rx_last;
    endsequence

    sequence seq_wrong_port_end;
        seq_end_beat ##0 (rx_dst_port != gcpd_pkg::CFG_PORT);
    endsequence

    AST_WRONG_PORT: assert property (@(posedge clk) disable iff (!resetn)
        seq_wrong_port_end |=> !cfg_update && cfg_reject)
        else $error("Packet on wrong port was committed");
    AST_BAD_CMD: assert property (@(posedge clk) disable iff (!resetn)
        (seq_end_beat ##0 chk_cmd_bad) |=> !cfg_update)
        else $error("Packet with wrong command was committed");
    AST_DDC_CMD_DEFAULT: assert property (@(posedge clk) disable iff (!resetn)
        (cfg_update && $past(sh_port[0]) == 16'h0000) |-> ddc_cmd_port == 16'h0401)
        else $error("DDC command port default not applied");
    AST_HP_TX_DEFAULT: assert property (@(posedge clk) disable iff (!resetn)
        (cfg_update && $past(sh_port[3]) == 16'h0000) |-> hp_tx_port == 16'h0401)
        else $error("Status source port default not applied");
    AST_DUC_RAW: assert property (@(posedge clk) disable iff (!resetn)
        (cfg_update && $past(sh_port[1]) != 16'h0000) |-> duc_cmd_port == $past(sh_port[1]))
        else $error("DUC command port not taken from packet");
    AST_DDC_SEL: assert property (@(posedge clk) disable iff (!resetn)
        ##1 ddc_sel_port == $past(ddc_base_port) + {9'h000, $past(ddc_sel)})
        else $error("DDC stream port is not base plus index");
    AST_WB_SEL: assert property (@(posedge clk) disable iff (!resetn)
        ##1 wb_sel_port == $past(wb_base_port) + {13'h0000, $past(wb_sel)})
        else $error("Wideband stream port is not base plus index");
    AST_WB_BITS_DEFAULT: assert property (@(posedge clk) disable iff (!resetn)
        (cfg_update && $past(sh_bits) == 8'h00) |-> wb_sample_bits == 8'h10)
        else $error("Wideband sample size default not applied");
    AST_HOLD: assert property (@(posedge clk) disable iff (!resetn)
        !cfg_update |-> $stable(wb_stream_enable) && $stable(filter_enable) &&
        $stable(ddc_base_port) && $stable(hw_timer_enable))
        else $error("Setting changed without a committed packet");
    AST_DISCOVERY_BIG: assert property (@(posedge clk) disable iff (!resetn)
        (discovery_done && !commit) |=> !little_endian [*1] ##0 $stable(data_format))
        else $error("Discovery did not restore big-endian");
endmodule : gcpd_decoder

/* File: dv/gcpd_host_model.sv */
`timescale 1ns/1ps
module gcpd_host_model (
    input wire logic clk,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic rx_last,
    output logic [15:0] rx_dst_port
);
    logic [7:0] pkt [0:63];
    initial
    begin
        rx_valid = 1'b0;
        rx_byte = 8'h00;
        rx_last = 1'b0;
        rx_dst_port = 16'h0000;
    end
    // Zero sequence number and general command; byte 39 zero keeps big-endian
    task clear_pkt;
        for (int i = 0; i < 64; i++)
        begin
            pkt[i] = 8'h00;
        end
    endtask : clear_pkt
    // Bytes go out on falling edges; idle lines show the inverse, never a stale copy
    task send_pkt(input int len, input logic [15:0] port, input bit gap);
        for (int i = 0; i < len; i++)
        begin
            @(negedge clk);
            rx_valid = 1'b1;
            rx_byte = pkt[i];
            rx_last = (i == len - 1);
            rx_dst_port = port;
            if (gap && i < len - 1)
            begin
                @(negedge clk);
                rx_valid = 1'b0;
                rx_byte = ~rx_byte;
                rx_dst_port = ~rx_dst_port;
            end
        end
        @(negedge clk);
        rx_valid = 1'b0;
        rx_last = 1'b0;
        rx_byte = ~rx_byte;
        rx_dst_port = ~rx_dst_port;
    endtask : send_pkt
endmodule : gcpd_host_model

/* File: dv/tb.sv */
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic [5:0] pos;
        logic pair;
        logic [7:0] hi;
        logic [7:0] lo;
        logic [4:0] sel;
        logic [15:0] exp;
    } gcpd_row_t;
    logic clk, resetn, rx_valid, rx_last, discovery_done;
    logic [7:0] rx_byte;
    logic [15:0] rx_dst_port;
    logic [6:0] ddc_sel;
    logic [2:0] wb_sel;
    logic [15:0] ddc_cmd_port, duc_cmd_port, hp_rx_port, hp_tx_port, ddc_audio_port;
    logic [15:0] duc_iq_port, ddc_base_port, mic_port, wb_base_port, ddc_sel_port;
    logic [15:0] wb_sel_port, wb_samples;
    logic [7:0] wb_stream_enable, wb_sample_bits, wb_rate_ms, wb_packets, data_format;
    logic [7:0] filter_enable;
    logic time_stamp_enable, vita49_enable, vna_mode, phase_word_mode, hw_timer_enable;
    logic little_endian, pa_enable, tuner_enable, common_freq_enable, clock_source;
    logic cfg_update, cfg_reject;
    logic [2:0] backplane_cfg;
    logic [1:0] ref_source;
    int failures = 0;
    int n_tests = 0;
    gcpd_row_t rows [0:20];
    logic [15:0] dflt [0:8];
    gcpd_host_model host_i (.clk(clk), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .rx_last(rx_last), .rx_dst_port(rx_dst_port));
    gcpd_decoder gcpd_decoder_i (.clk(clk), .resetn(resetn), .rx_valid(rx_valid),
        .rx_byte(rx_byte), .rx_last(rx_last), .rx_dst_port(rx_dst_port),
        .discovery_done(discovery_done), .ddc_sel(ddc_sel), .wb_sel(wb_sel),
        .ddc_cmd_port(ddc_cmd_port), .duc_cmd_port(duc_cmd_port), .hp_rx_port(hp_rx_port),
        .hp_tx_port(hp_tx_port), .ddc_audio_port(ddc_audio_port), .duc_iq_port(duc_iq_port),
        .ddc_base_port(ddc_base_port), .mic_port(mic_port), .wb_base_port(wb_base_port),
        .ddc_sel_port(ddc_sel_port), .wb_sel_port(wb_sel_port),
        .wb_stream_enable(wb_stream_enable), .wb_samples(wb_samples),
        .wb_sample_bits(wb_sample_bits), .wb_rate_ms(wb_rate_ms), .wb_packets(wb_packets),
        .time_stamp_enable(time_stamp_enable), .vita49_enable(vita49_enable),
        .vna_mode(vna_mode), .phase_word_mode(phase_word_mode),
        .hw_timer_enable(hw_timer_enable), .data_format(data_format),
        .little_endian(little_endian), .backplane_cfg(backplane_cfg),
        .ref_source(ref_source), .pa_enable(pa_enable), .tuner_enable(tuner_enable),
        .common_freq_enable(common_freq_enable), .clock_source(clock_source),
        .filter_enable(filter_enable), .cfg_update(cfg_update), .cfg_reject(cfg_reject));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Output picked by a row's selector, widened to 16 bits
    function automatic logic [15:0] pick(input logic [4:0] sel);
        case (sel)
            5'h00: pick = ddc_cmd_port;
            5'h01: pick = duc_cmd_port;
            5'h02: pick = hp_rx_port;
            5'h03: pick = hp_tx_port;
            5'h04: pick = ddc_audio_port;
            5'h05: pick = duc_iq_port;
            5'h06: pick = ddc_base_port;
            5'h07: pick = mic_port;
            5'h08: pick = wb_base_port;
            5'h09: pick = {8'h00, wb_stream_enable};
            5'h0a: pick = wb_samples;
            5'h0b: pick = {8'h00, wb_sample_bits};
            5'h0c: pick = {8'h00, wb_rate_ms};
            5'h0d: pick = {8'h00, wb_packets};
            5'h0e: pick = {12'h000, phase_word_mode, vna_mode, vita49_enable, time_stamp_enable};
            5'h0f: pick = {15'h0000, hw_timer_enable};
            5'h10: pick = {8'h00, data_format};
            5'h11: pick = {13'h0000, backplane_cfg};
            5'h12: pick = {14'h0000, ref_source};
            5'h13: pick = {12'h000, clock_source, common_freq_enable, tuner_enable, pa_enable};
            default: pick = {8'h00, filter_enable};
        endcase
    endfunction : pick
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task end_sim;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim
    // Guard against a hang anywhere in the sequence
    initial
    begin
        repeat (100000) @(posedge clk);
        failures++;
        end_sim();
    end
    initial
    begin
        resetn = 1'b0;
        discovery_done = 1'b0;
        ddc_sel = 7'h00;
        wb_sel = 3'h0;
        dflt = '{16'h0401, 16'h0402, 16'h0403, 16'h0401, 16'h0404,
            16'h0405, 16'h040b, 16'h0402, 16'h0403};
        rows = '{'{6'h05, 1, 8'h12, 8'h34, 5'h00, 16'h1234}, '{6'h07, 1, 8'h23, 8'h45, 5'h01, 16'h2345},
            '{6'h09, 1, 8'h34, 8'h56, 5'h02, 16'h3456}, '{6'h0b, 1, 8'h45, 8'h67, 5'h03, 16'h4567},
            '{6'h0d, 1, 8'h56, 8'h78, 5'h04, 16'h5678}, '{6'h0f, 1, 8'h67, 8'h89, 5'h05, 16'h6789},
            '{6'h11, 1, 8'hff, 8'hb0, 5'h06, 16'hffb0}, '{6'h13, 1, 8'h89, 8'hab, 5'h07, 16'h89ab},
            '{6'h15, 1, 8'h9a, 8'hbc, 5'h08, 16'h9abc}, '{6'h17, 0, 8'ha5, 8'h00, 5'h09, 16'h00a5},
            '{6'h18, 1, 8'h01, 8'h2c, 5'h0a, 16'h012c}, '{6'h1a, 0, 8'h00, 8'h00, 5'h0b, 16'h0010},
            '{6'h1b, 0, 8'hff, 8'h00, 5'h0c, 16'h00ff}, '{6'h1c, 0, 8'h40, 8'h00, 5'h0d, 16'h0040},
            '{6'h25, 0, 8'h0a, 8'h00, 5'h0e, 16'h000a}, '{6'h26, 0, 8'h01, 8'h00, 5'h0f, 16'h0001},
            '{6'h28, 0, 8'hff, 8'h00, 5'h10, 16'h0000}, '{6'h38, 0, 8'hff, 8'h00, 5'h11, 16'h0007},
            '{6'h39, 0, 8'h02, 8'h00, 5'h12, 16'h0002}, '{6'h3a, 0, 8'h0a, 8'h00, 5'h13, 16'h000a},
            '{6'h3b, 0, 8'h5a, 8'h00, 5'h14, 16'h005a}};
        repeat (6) @(negedge clk);
        for (int i = 0; i < 9; i++) chk(pick(i), dflt[i], "reset port");
        chk(wb_samples, 16'h0200, "reset samples");
        chk({wb_sample_bits, wb_rate_ms}, 16'h1014, "reset bits rate");
        resetn = 1'b1;
        ddc_sel = 7'h4f;
        wb_sel = 3'h7;
        @(negedge clk);
        chk(ddc_sel_port, 16'h045a, "ddc lookup");
        chk(wb_sel_port, 16'h040a, "wb lookup");
        // One packet per row, every other byte zero
        foreach (rows[r])
        begin
            host_i.clear_pkt();
            host_i.pkt[rows[r].pos] = rows[r].hi;
            if (rows[r].pair) host_i.pkt[rows[r].pos + 1] = rows[r].lo;
            host_i.send_pkt(60, 16'h0400, 1'b0);
            chk(cfg_update, 1'b1, "update");
            chk(pick(rows[r].sel), rows[r].exp, "field");
        end
        // Zero port fields with gaps between bytes fall back to defaults
        host_i.clear_pkt();
        host_i.send_pkt(60, 16'h0400, 1'b1);
        for (int i = 0; i < 9; i++) chk(pick(i), dflt[i], "zero port");
        host_i.pkt[17] = 8'h20;
        host_i.pkt[21] = 8'h30;
        host_i.send_pkt(60, 16'h0400, 1'b0);
        @(negedge clk);
        chk(ddc_sel_port, 16'h204f, "ddc base plus 79");
        chk(wb_sel_port, 16'h3007, "wb base plus 7");
        // Wrong port, wrong command, one byte short: all refused, nothing changes
        for (int k = 0; k < 3; k++)
        begin
            host_i.clear_pkt();
            host_i.pkt[5] = 8'h55;
            host_i.pkt[4] = (k == 1) ? 8'h01 : 8'h00;
            host_i.send_pkt((k == 2) ? 59 : 60, (k == 0) ? 16'h0401 : 16'h0400, 1'b0);
            chk({cfg_reject, cfg_update}, 16'h0002, "refused");
            chk(ddc_cmd_port, 16'h0401, "kept port");
        end
        // Big-endian packet picks little order, which the next packet then uses
        host_i.clear_pkt();
        host_i.pkt[5] = 8'h04;
        host_i.pkt[6] = 8'h10;
        host_i.pkt[39] = 8'h02;
        host_i.send_pkt(60, 16'h0400, 1'b0);
        chk(ddc_cmd_port, 16'h0410, "first order");
        chk({little_endian, data_format}, 16'h0102, "order flag");
        host_i.pkt[5] = 8'h10;
        host_i.pkt[6] = 8'h04;
        host_i.pkt[24] = 8'h2c;
        host_i.pkt[25] = 8'h01;
        host_i.send_pkt(60, 16'h0400, 1'b0);
        chk(ddc_cmd_port, 16'h0410, "little order");
        chk(wb_samples, 16'h012c, "little samples");
        chk(little_endian, 1'b1, "order kept");
        discovery_done = 1'b1;
        @(negedge clk);
        discovery_done = 1'b0;
        chk(little_endian, 1'b0, "discovery order");
        host_i.pkt[5] = 8'h04;
        host_i.pkt[6] = 8'h10;
        host_i.send_pkt(60, 16'h0400, 1'b0);
        chk(ddc_cmd_port, 16'h0410, "after discovery");
        resetn = 1'b0;
        @(negedge clk);
        chk(ddc_cmd_port, 16'h0401, "mid reset");
        chk(little_endian, 1'b0, "mid reset order");
        resetn = 1'b1;
        end_sim();
    end
endmodule : tb
